// >>> core/tps_pkg.sv
// shared constants and types for the three-rail power sequencer
package tps_pkg;
   // -------------------------------------------------------------
   // clock and sequence-oscillator timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int OSC_PS_PER_NF = 120_000_000; // 120 us per nF
   localparam int TIMING_CAP_NF = 10;
   // full sequence-clock period in core cycles, from cap and rate
   localparam int OSC_PERIOD_CYCLES = (OSC_PS_PER_NF / CLK_PERIOD_PS) * TIMING_CAP_NF;

   // -------------------------------------------------------------
   // sequence delays, in sequence-clock ticks
   // -------------------------------------------------------------
   localparam logic [3:0] FIRST_DELAY_TICKS = 4'hA; // released after 9..10 periods
   localparam logic [3:0] STEP_DELAY_TICKS = 4'h8;
   localparam int NUM_RAILS = 3;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [1:0] LEVEL_RESET = 2'h0;
   localparam logic [3:0] COUNT_RESET = 4'h0;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_UP   = 4'b0010,
      SEQ_ON   = 4'b0100,
      SEQ_DOWN = 4'b1000
   } tps_state_type;

   typedef struct packed {
      logic tick;   // one-cycle pulse, end of each period
      logic charge; // capacitor ramp rising
   } tps_osc_type;
endpackage

// >>> core/tps_osc.sv
// sequence clock: triangle ramp model of the timing capacitor
`timescale 1ns/1ps
module tps_osc #(
   parameter int PERIOD_CYCLES = tps_pkg::OSC_PERIOD_CYCLES
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   output tps_pkg::tps_osc_type osc_o
);
   localparam int HALF = PERIOD_CYCLES / 2;

   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   tps_pkg::tps_osc_type osc_ff;
   tps_pkg::tps_osc_type nxt_osc;

   // ramp charges for the first half, discharges for the second
   always_comb begin
      nxt_cnt = cnt_ff + 32'h0000_0001;
      nxt_osc.tick = 1'b0;
      nxt_osc.charge = osc_ff.charge;
      if (cnt_ff == 32'(HALF - 1)) begin
         nxt_osc.charge = 1'b0;
      end
      if (cnt_ff == 32'(PERIOD_CYCLES - 1)) begin
         nxt_cnt = 32'h0000_0000;
         nxt_osc.charge = 1'b1;
         nxt_osc.tick = 1'b1;
      end
      if (!resetn_i) begin
         nxt_cnt = 32'h0000_0000;
         nxt_osc = '{tick: 1'b0, charge: 1'b1};
      end
   end

   always_ff @(posedge clk_i) begin
      cnt_ff <= nxt_cnt;
      osc_ff <= nxt_osc;
   end

   assign osc_o = osc_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   osc_period_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      osc_ff.tick |-> cnt_ff == 32'h0000_0000 && $past(cnt_ff) == 32'(PERIOD_CYCLES - 1))
      else $error("sequence tick off its period");
endmodule

// >>> core/tps_sequencer.sv
// three-rail power sequencer core with open-drain rail outputs
// -------------------------------------------------------------
// Functional notes
// - all rails inactive until enable asserted
// - first rail released after 9 to 10 periods
// - second rail released eight periods after first
// - third rail released eight periods after second
// - enable drop after full power-up starts timer
// - power-down third, second, first; 10/8/8 ticks
// - invert input flips sense of all rails
// - sequence clock period set by timing capacitor
// - early enable drop fully resets counter
// - partial power-up drop gives controlled shutdown
// -------------------------------------------------------------
`timescale 1ns/1ps
module tps_sequencer #(
   parameter int OSC_PERIOD_CYCLES = tps_pkg::OSC_PERIOD_CYCLES
) (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   // control pins
   input wire logic ENABLE_I,
   input wire logic OUTPUT_POLARITY_SELECT_I,
   // open-drain rail pins, bit 0 is rail 1
   input wire logic [2:0] RAIL_RELEASE_OUT_I,
   output logic [2:0] RAIL_RELEASE_OUT_O,
   output logic [2:0] RAIL_RELEASE_OUT_OE_N_O,
   // ramp phase of the timing capacitor node
   output logic TIMING_CAPACITOR_NODE_O
);
   // -------------------------------------------------------------
   // sequence clock
   // -------------------------------------------------------------
   tps_pkg::tps_osc_type osc;

   tps_osc #(
      .PERIOD_CYCLES(OSC_PERIOD_CYCLES)
   ) u_osc (
      .clk_i(CORE_CLK_I),
      .resetn_i(RESETN_I),
      .osc_o(osc)
   );

   // -------------------------------------------------------------
   // sequencing state
   // -------------------------------------------------------------
   tps_pkg::tps_state_type state_ff, nxt_state;
   logic [1:0] level_ff, nxt_level;     // rails released
   logic [3:0] count_ff, nxt_count;     // ticks in current step
   logic first_ff, nxt_first;           // first step of a ramp
   logic [2:0] rel_ff, nxt_rel;
   logic [2:0] oe_n_ff, nxt_oe_n;
   logic node_ff, nxt_node;

   function automatic logic [2:0] level_mask(input logic [1:0] lvl);
      unique case (lvl)
         2'h0: level_mask = 3'b000;
         2'h1: level_mask = 3'b001;
         2'h2: level_mask = 3'b011;
         default: level_mask = 3'b111;
      endcase
   endfunction

   logic [3:0] target;
   logic step_done;

   always_comb begin
      target = first_ff ? tps_pkg::FIRST_DELAY_TICKS : tps_pkg::STEP_DELAY_TICKS;
      step_done = osc.tick && (count_ff + 4'h1 == target);
      nxt_state = state_ff;
      nxt_level = level_ff;
      nxt_count = count_ff;
      nxt_first = first_ff;
      if (osc.tick) begin
         nxt_count = count_ff + 4'h1;
      end
      unique case (state_ff)
         tps_pkg::SEQ_IDLE: begin
            nxt_count = tps_pkg::COUNT_RESET;
            nxt_first = 1'b1;
            if (ENABLE_I) begin
               nxt_state = tps_pkg::SEQ_UP;
            end
         end
         tps_pkg::SEQ_UP: begin
            if (!ENABLE_I) begin
               nxt_count = tps_pkg::COUNT_RESET;
               nxt_first = 1'b1;
               // nothing out yet: a glitch just rearms the counter
               nxt_state = (level_ff == 2'h0) ? tps_pkg::SEQ_IDLE
                                              : tps_pkg::SEQ_DOWN;
            end else if (step_done) begin
               nxt_level = level_ff + 2'h1;
               nxt_count = tps_pkg::COUNT_RESET;
               nxt_first = 1'b0;
               if (level_ff == 2'h2) begin
                  nxt_state = tps_pkg::SEQ_ON;
               end
            end
         end
         tps_pkg::SEQ_ON: begin
            nxt_count = tps_pkg::COUNT_RESET;
            nxt_first = 1'b1;
            if (!ENABLE_I) begin
               nxt_state = tps_pkg::SEQ_DOWN;
            end
         end
         tps_pkg::SEQ_DOWN: begin
            // enable is ignored until every rail is back off
            if (step_done) begin
               nxt_level = level_ff - 2'h1;
               nxt_count = tps_pkg::COUNT_RESET;
               nxt_first = 1'b0;
               if (level_ff == 2'h1) begin
                  nxt_state = tps_pkg::SEQ_IDLE;
               end
            end
         end
      endcase
      nxt_rel = level_mask(nxt_level);
      nxt_oe_n = nxt_rel ^ {3{OUTPUT_POLARITY_SELECT_I}};
      nxt_node = osc.charge;
      if (!RESETN_I) begin
         nxt_state = tps_pkg::SEQ_IDLE;
         nxt_level = tps_pkg::LEVEL_RESET;
         nxt_count = tps_pkg::COUNT_RESET;
         nxt_first = 1'b1;
         nxt_rel = 3'b000;
         nxt_oe_n = {3{OUTPUT_POLARITY_SELECT_I}};
         nxt_node = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      state_ff <= nxt_state;
      level_ff <= nxt_level;
      count_ff <= nxt_count;
      first_ff <= nxt_first;
      rel_ff <= nxt_rel;
      oe_n_ff <= nxt_oe_n;
      node_ff <= nxt_node;
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // open drain: data is always low, only the enable moves
   logic [2:0] zero_ff;

   always_ff @(posedge CORE_CLK_I) begin
      zero_ff <= 3'b000;
   end

   assign RAIL_RELEASE_OUT_O = zero_ff;
   assign RAIL_RELEASE_OUT_OE_N_O = oe_n_ff;
   assign TIMING_CAPACITOR_NODE_O = node_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   logic [3:0] en_ticks_ff, nxt_en_ticks;

   // held clear while idle: a tick in the cycle that takes enable is not
   // part of the power-up delay and would skew the reference by one
   always_comb begin
      nxt_en_ticks = en_ticks_ff;
      if (osc.tick && en_ticks_ff != 4'hF) begin
         nxt_en_ticks = en_ticks_ff + 4'h1;
      end
      if (!RESETN_I || !ENABLE_I || state_ff == tps_pkg::SEQ_IDLE
          || state_ff == tps_pkg::SEQ_DOWN) begin
         nxt_en_ticks = 4'h0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      en_ticks_ff <= nxt_en_ticks;
   end

   idle_all_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (state_ff == tps_pkg::SEQ_IDLE && !ENABLE_I) |=> rel_ff == 3'b000)
      else $error("rail released while idle");

   first_release_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      $rose(rel_ff[0]) |-> en_ticks_ff == tps_pkg::FIRST_DELAY_TICKS && $past(osc.tick))
      else $error("first rail not on the tenth tick");

   second_release_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      $rose(rel_ff[1]) |-> rel_ff[0] && $past(count_ff) == tps_pkg::STEP_DELAY_TICKS - 4'h1
         && $past(osc.tick))
      else $error("second rail delay wrong");

   third_release_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      $rose(rel_ff[2]) |-> rel_ff[1] && $past(count_ff) == tps_pkg::STEP_DELAY_TICKS - 4'h1
         && $past(osc.tick))
      else $error("third rail delay wrong");

   down_start_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (state_ff == tps_pkg::SEQ_ON && !ENABLE_I) |=> state_ff == tps_pkg::SEQ_DOWN
         ##1 (rel_ff == 3'b111) [*2])
      else $error("power-down not started correctly");

   down_third_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      $fell(rel_ff[2]) |-> $past(count_ff) == tps_pkg::FIRST_DELAY_TICKS - 4'h1
         && $past(first_ff))
      else $error("third rail off delay wrong");

   polarity_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      ##1 RAIL_RELEASE_OUT_OE_N_O == (rel_ff ^ {3{$past(OUTPUT_POLARITY_SELECT_I)}}))
      else $error("rail sense does not follow polarity select");

   glitch_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (state_ff == tps_pkg::SEQ_UP && level_ff == 2'h0 && !ENABLE_I)
         |=> state_ff == tps_pkg::SEQ_IDLE && rel_ff == 3'b000)
      else $error("early enable drop did not reset");

   abort_down_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (state_ff == tps_pkg::SEQ_UP && level_ff != 2'h0 && !ENABLE_I)
         |=> state_ff == tps_pkg::SEQ_DOWN && $stable(rel_ff))
      else $error("partial power-up not shut down");

   reverse_order_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      ($fell(rel_ff[0]) || $fell(rel_ff[1])) |-> rel_ff[2] == 1'b0
         && (!$fell(rel_ff[0]) || rel_ff[1] == 1'b0))
      else $error("rails not released in reverse order");
endmodule

// >>> dv/tps_regulator_model.sv
// regulator enable pins on the open-drain rails, with pull-ups
`timescale 1ns/1ps
module tps_regulator_model (
   // rail pins as driven by the sequencer
   input wire logic [2:0] oe_n_i,
   input wire logic [2:0] data_i,
   input wire logic en_active_low_i,
   // wire level and supply state
   output logic [2:0] pin_o,
   output logic [2:0] rail_on_o
);
   // ----------------------------------------------------------
   // wire resolution
   // ----------------------------------------------------------
   // a released pin floats up to the pull-up, never keeps old data
   assign pin_o = oe_n_i | data_i;
   // regulator enable sense is picked to match the invert strap
   assign rail_on_o = pin_o ^ {3{en_active_low_i}};
endmodule

// >>> dv/tps_sequencer_tb.sv
// self-checking bench: rail order, delays, polarity, glitch and abort
`timescale 1ns/1ps
module tps_sequencer_tb;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   localparam int P = 8;
   typedef struct {logic [2:0] v; int lo; int hi;} tps_note_type;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic en = 1'b0;
   logic output_polarity_select = 1'b0;
   logic [2:0] pin, dat, oen, on, last;
   logic node, last_node;
   tps_note_type q[$];
   tps_note_type n;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int mark = 0;
   int rise = 0;
   int seed = 57587;
   always #2.5 clk = ~clk;
   tps_sequencer #(.OSC_PERIOD_CYCLES(P)) tps_sequencer_inst (
      .CORE_CLK_I(clk), .RESETN_I(rstn), .ENABLE_I(en), .OUTPUT_POLARITY_SELECT_I(output_polarity_select),
      .RAIL_RELEASE_OUT_I(pin), .RAIL_RELEASE_OUT_O(dat), .RAIL_RELEASE_OUT_OE_N_O(oen),
      .TIMING_CAPACITOR_NODE_O(node));
   tps_regulator_model tps_regulator_model_inst (
      .oe_n_i(oen), .data_i(dat), .en_active_low_i(output_polarity_select), .pin_o(pin), .rail_on_o(on));
   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // first step waits 9..10 periods plus sampling slack, later ones exactly 8
   function automatic tps_note_type mk(input logic [2:0] v, input bit first);
      return '{v, first ? 9 * P : 8 * P, first ? 10 * P + 3 : 8 * P};
   endfunction
   task automatic do_reset(input logic pol);
      @(negedge clk) rstn = 1'b0;
      output_polarity_select = pol;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      check("reset rails", oen, {3{pol}});
      check("reset data", dat, 3'h0);
   endtask
   task automatic run(input int hold, input int n_up);
      logic [2:0] m;
      m = 3'h0;
      for (int k = 0; k < n_up; k++) begin
         m[k] = 1'b1;
         q.push_back(mk(m ^ {3{output_polarity_select}}, k == 0));
      end
      @(negedge clk) en = 1'b1;
      mark = cyc;
      repeat (hold) @(negedge clk);
      if (n_up == 3) check("regulators on", on, 3'h7);
      for (int k = n_up - 1; k >= 0; k--) begin
         m[k] = 1'b0;
         q.push_back(mk(m ^ {3{output_polarity_select}}, k == n_up - 1));
      end
      en = 1'b0;
      mark = cyc;
      repeat (30 * P) @(negedge clk);
      check("steps left", q.size(), 0);
      $display("test done hold %0d rails %0d invert %0b", hold, n_up, output_polarity_select);
   endtask
   // ----------------------------------------------------------
   // timeout and output watcher
   // ----------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_count++;
         give_verdict();
      end
   end
   always @(negedge clk) begin
      if (rstn) begin
         if (node && !last_node) begin
            if (rise > 0) check("osc period", cyc - rise, P);
            rise = cyc;
         end
         if (oen !== last) begin
            check("open-drain data", dat, 3'h0);
            if (q.size() == 0) begin
               check("spurious step", oen, last);
            end else begin
               n = q.pop_front();
               check("rail state", oen, n.v);
               check("step delay", cyc - mark >= n.lo && cyc - mark <= n.hi, 1);
            end
            mark = cyc;
         end
      end else begin
         rise = 0;
      end
      last = oen;
      last_node = node;
   end
   // ----------------------------------------------------------
   // main sequence: full cycle, glitch, abort after rail 1 and 2
   // ----------------------------------------------------------
   initial begin
      for (int p = 0; p < 2; p++) begin
         do_reset(p[0]);
         run(30 * P, 3);
         run(1 + ($random(seed) & 63), 0);
         run(10 * P + 3 + ($random(seed) & 31), 1);
         run(18 * P + 3 + ($random(seed) & 31), 2);
      end
      give_verdict();
   end
endmodule
